// >>> shared/stl_pkg.sv
// Shared constants and types for the serial link transport/link layer block
package stl_pkg;
  // Primitive words; control character sits in the low byte
  localparam logic [31:0] P_ALIGN = 32'h7b4a4abc;
  localparam logic [31:0] P_SYNC  = 32'hb5b5957c;
  localparam logic [31:0] P_SOF   = 32'h3737b57c;
  localparam logic [31:0] P_EOF   = 32'hd5d5b57c;
  localparam logic [31:0] P_HOLD  = 32'hd5d5aa7c;
  localparam logic [31:0] P_HOLDA = 32'h9595aa7c;
  localparam logic [31:0] P_RIP   = 32'h5555b57c;
  localparam logic [31:0] P_ROK   = 32'h3535b57c;
  localparam logic [31:0] P_RERR  = 32'h5656b57c;
  localparam logic [31:0] P_XRDY  = 32'h5757b57c;
  localparam logic [31:0] P_RRDY  = 32'h4a4a957c;
  localparam logic [31:0] P_WTRM  = 32'h5858b57c;
  localparam logic [31:0] P_DMAT  = 32'h3636b57c;
  // Scrambler and CRC
  localparam logic [15:0] SCR_SEED = 16'hffff;
  localparam logic [15:0] SCR_POLY = 16'ha011;
  localparam logic [10:0] SCR_LAST = 11'h7ff;
  localparam logic [31:0] CRC_SEED = 32'h52325032;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  // ALIGN spacing and frame types
  localparam logic [7:0]  ALIGN_MAX  = 8'hfe;
  localparam logic [7:0]  FT_DATA    = 8'h46;
  localparam logic [7:0]  FT_VEND_A  = 8'hc7;
  localparam logic [7:0]  FT_VEND_B  = 8'hd4;
  // Receive FIFO and transmit buffer geometry
  localparam int unsigned RF_DEPTH = 16;
  localparam logic [4:0]  RF_FULL  = 5'h10;
  localparam logic [1:0]  TB_FULL  = 2'h2;

  typedef struct packed {
    logic [31:0] data;
    logic        isK;
    logic        errDisp;
    logic        errCode;
  } stl_phy_word_type;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } stl_tx_word_type;

  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_TRDY  = 10'h002,
    ST_TSOF  = 10'h004,
    ST_TDATA = 10'h008,
    ST_TCRC  = 10'h010,
    ST_TEOF  = 10'h020,
    ST_TWAIT = 10'h040,
    ST_RRDY  = 10'h080,
    ST_RDATA = 10'h100,
    ST_REND  = 10'h200
  } stl_state_type;
endpackage : stl_pkg

// >>> rtl/stl_transport_link.sv
// Transport and link layer framer with scrambler, CRC, flow control, ALIGN insertion
`timescale 1ns/1ps

module stl_transport_link import stl_pkg::*; (
  input  logic             clk_sys,
  input  logic             rst_n,
  input  stl_tx_word_type  txWord,
  input  logic             txValid,
  output logic             txReady,
  input  logic             txStart,
  input  logic             txIsData,
  input  logic [4:0]       txLen,
  input  logic             sendCtrlFrameReq,
  output logic             txOk,
  output logic             txNotOk,
  output logic             txErr,
  output logic [31:0]      rxOut,
  output logic             rxOutValid,
  input  logic             rxOutReady,
  output logic             rxFisGood,
  output logic             rxDataFis,
  output logic             rxVendorLong,
  output logic             rxCrcOk,
  output logic             rxCrcBad,
  output logic             rxErrDisp,
  output logic             rxErrCode,
  output logic             rxErr,
  input  stl_phy_word_type phyRx,
  input  logic             phyReady,
  output logic [31:0]      phyTxData,
  output logic             phyTxIsK,
  input  logic [3:0]       cfgRxThresh,
  input  logic [7:0]       cfgAlignRate,
  input  logic [1:0]       lowPowerEnableBits,
  input  logic             cfgGen2,
  input  logic             pmReq,
  output logic             pmStart,
  output logic             lineGen2,
  output logic             linkUp,
  output logic             linkChange
);

  // Scrambler step: 32 output bits per word, Galois form of the 16th order polynomial
  function automatic logic [47:0] scrStep(input logic [15:0] s);
    logic [15:0] t;
    logic [31:0] o;
    t = s;
    o = '0;
    for (int i = 0; i < 32; i++) begin
      o[i] = t[15];
      t = {t[14:0], 1'b0} ^ (t[15] ? SCR_POLY : 16'h0000);
    end
    return {t, o};
  endfunction : scrStep

  // CRC step over one word, most significant bit first
  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction : crcStep

  stl_state_type    st_r, st_nxt;
  stl_phy_word_type rxMeta_r, rxS_r;
  logic             rdyMeta_r, rdyS_r, rdyPrev_r;
  stl_tx_word_type  tbMem [2];
  logic             tbWp_r, tbRp_r;
  logic [1:0]       tbCnt_r;
  logic [31:0]      ctlMem [32];
  logic [31:0]      rfMem [RF_DEPTH];
  logic [3:0]       rfWp_r, rfRp_r;
  logic [4:0]       rfCnt_r;
  logic             txPend_r, isData_r, retry_r, farHold_r;
  logic [4:0]       len_r, idx_r;
  logic [7:0]       alignRate_r, alignCnt_r;
  logic [3:0]       rxThresh_r;
  logic [1:0]       alignLeft_r;
  logic [15:0]      scrTx_r, scrRx_r;
  logic [10:0]      scrTxCnt_r, scrRxCnt_r;
  logic [31:0]      txCrc_r, rxCrc_r, pendWord_r;
  logic             pendV_r, rxFirst_r, rxBad_r, vendor_r, vSig_r, isDataRx_r;
  logic [31:0]      txWordNxt;
  logic             txKNxt;

  // Two-flop synchronisers on everything arriving from the PHY pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxMeta_r  <= '0;
      rxS_r     <= '0;
      rdyMeta_r <= 1'b0;
      rdyS_r    <= 1'b0;
      rdyPrev_r <= 1'b0;
    end else begin
      rxMeta_r  <= phyRx;
      rxS_r     <= rxMeta_r;
      rdyMeta_r <= phyReady;
      rdyS_r    <= rdyMeta_r;
      rdyPrev_r <= rdyS_r;
    end
  end

  // Received primitive decode; ALIGN words fall through and are simply ignored
  wire rxPrim  = rxS_r.isK;
  wire rxDataW = !rxS_r.isK;
  wire rxSync  = rxPrim && (rxS_r.data == P_SYNC);
  wire rxXrdy  = rxPrim && (rxS_r.data == P_XRDY);
  wire rxRrdy  = rxPrim && (rxS_r.data == P_RRDY);
  wire rxSof   = rxPrim && (rxS_r.data == P_SOF);
  wire rxEof   = rxPrim && (rxS_r.data == P_EOF);
  wire rxHold  = rxPrim && (rxS_r.data == P_HOLD);
  wire rxRok   = rxPrim && (rxS_r.data == P_ROK);
  wire rxRerr  = rxPrim && (rxS_r.data == P_RERR);
  wire rxWtrm  = rxPrim && (rxS_r.data == P_WTRM);
  wire rxDmat  = rxPrim && (rxS_r.data == P_DMAT);
  wire rxAlign = rxPrim && (rxS_r.data == P_ALIGN);

  // Transmit source: the two-entry buffer, or the saved copy on a retry
  wire        alignNow = alignLeft_r != 2'h0;
  wire        srcValid = retry_r || (tbCnt_r != 2'h0);
  wire [31:0] srcWord  = retry_r ? ctlMem[idx_r] : tbMem[tbRp_r].data;
  wire        lenEnd   = idx_r == (len_r - 5'h01);
  wire        srcLast  = isData_r ? tbMem[tbRp_r].last : lenEnd;
  wire        take     = (st_r == ST_TDATA) && !alignNow && !farHold_r && srcValid;
  wire        tbPush   = txValid && txReady;
  wire        tbPop    = take && !retry_r;
  wire        txBusy   = (st_r == ST_TSOF) || (st_r == ST_TDATA) || (st_r == ST_TCRC)
                         || (st_r == ST_TEOF) || (st_r == ST_TWAIT);
  wire        txFault  = txBusy && (rxSync || !rdyS_r);
  wire [47:0] scrTxN   = scrStep(scrTx_r);
  wire [47:0] scrRxN   = scrStep(scrRx_r);
  wire        scrTxAdv = take || ((st_r == ST_TCRC) && !alignNow);
  assign txReady = tbCnt_r != TB_FULL;

  // Receive side: one-word delay so the last data word before EOF is the CRC
  wire [31:0] rxDw     = rxS_r.data ^ scrRxN[31:0];
  wire        rxTake   = (st_r == ST_RDATA) && rxDataW;
  wire        rfPushRq = rxTake && pendV_r;
  wire        rfPush   = rfPushRq && (rfCnt_r != RF_FULL);
  wire        rfPop    = rxOutValid && rxOutReady;
  wire        rxHoldRq = rfCnt_r > {1'b0, rxThresh_r};
  wire        crcMatch = pendV_r && (pendWord_r == rxCrc_r);
  wire        rxFrmErr = (st_r == ST_RDATA) && (rxS_r.errDisp || rxS_r.errCode);
  wire        rxAbort  = (st_r == ST_RDATA) && (rxSync || !rdyS_r);
  wire [7:0]  rateEff  = ((cfgAlignRate == 8'h00) || (cfgAlignRate > ALIGN_MAX))
                         ? ALIGN_MAX : cfgAlignRate;
  wire        frmType  = (pendWord_r[7:0] == FT_VEND_A) || (pendWord_r[7:0] == FT_VEND_B);
  assign rxOut      = rfMem[rfRp_r];
  assign rxOutValid = rfCnt_r != 5'h00;

  // Link state machine: idle arbitration, transmit and receive sequences
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:  if (rxXrdy) st_nxt = ST_RRDY;
                else if (txPend_r) st_nxt = ST_TRDY;
      ST_TRDY:  if (rxXrdy) st_nxt = ST_RRDY;
                else if (rxRrdy && !alignNow) st_nxt = ST_TSOF;
      ST_TSOF:  if (!alignNow) st_nxt = ST_TDATA;
      ST_TDATA: if (rxDmat || sendCtrlFrameReq || (take && srcLast)) st_nxt = ST_TCRC;
      ST_TCRC:  if (!alignNow) st_nxt = ST_TEOF;
      ST_TEOF:  if (!alignNow) st_nxt = ST_TWAIT;
      ST_TWAIT: if (rxRok || rxRerr) st_nxt = ST_IDLE;
      ST_RRDY:  if (rxSof) st_nxt = ST_RDATA;
                else if (rxSync) st_nxt = ST_IDLE;
      ST_RDATA: if (rxEof || rxWtrm) st_nxt = ST_REND;
                else if (sendCtrlFrameReq) st_nxt = ST_IDLE;
      ST_REND:  if (rxSync) st_nxt = ST_IDLE;
    endcase
    // Link loss and unexpected SYNC win over everything else
    if (txFault || rxAbort || !rdyS_r) st_nxt = ST_IDLE;
  end

  // Transmit word selection; one direction of payload at a time
  always_comb begin
    txKNxt    = 1'b1;
    txWordNxt = P_SYNC;
    if (alignNow) txWordNxt = P_ALIGN;
    else begin
      unique case (st_r)
        ST_IDLE:  txWordNxt = P_SYNC;
        ST_TRDY:  txWordNxt = P_XRDY;
        ST_TSOF:  txWordNxt = P_SOF;
        ST_TDATA: if (farHold_r) txWordNxt = P_HOLDA;
                  else if (!srcValid) txWordNxt = P_HOLD;
                  else begin
                    txWordNxt = srcWord ^ scrTxN[31:0];
                    txKNxt    = 1'b0;
                  end
        ST_TCRC:  begin
                    txWordNxt = txCrc_r ^ scrTxN[31:0];
                    txKNxt    = 1'b0;
                  end
        ST_TEOF:  txWordNxt = P_EOF;
        ST_TWAIT: txWordNxt = P_WTRM;
        ST_RRDY:  txWordNxt = P_RRDY;
        ST_RDATA: if (rxHoldRq) txWordNxt = P_HOLD;
                  else if (farHold_r) txWordNxt = P_HOLDA;
                  else txWordNxt = P_RIP;
        ST_REND:  txWordNxt = rxBad_r ? P_RERR : P_ROK;
      endcase
    end
  end

  // State, output word and ALIGN spacing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r        <= ST_IDLE;
      phyTxData   <= P_SYNC;
      phyTxIsK    <= 1'b1;
      alignCnt_r  <= 8'h00;
      alignLeft_r <= 2'h0;
    end else begin
      st_r      <= st_nxt;
      phyTxData <= txWordNxt;
      phyTxIsK  <= txKNxt;
      if (alignNow) alignLeft_r <= alignLeft_r - 2'h1;
      else if (alignCnt_r >= alignRate_r - 8'h01) begin
        alignLeft_r <= 2'h2;
        alignCnt_r  <= 8'h00;
      end else alignCnt_r <= alignCnt_r + 8'h01;
    end
  end

  // Frame bookkeeping: request latch, retry, configuration sampled in idle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      txPend_r <= 1'b0;
      isData_r <= 1'b0;
      retry_r  <= 1'b0;
      len_r    <= 5'h00;
      idx_r    <= 5'h00;
      farHold_r   <= 1'b0;
      alignRate_r <= ALIGN_MAX;
      rxThresh_r  <= 4'h0;
    end else begin
      if (st_r == ST_IDLE) begin
        alignRate_r <= rateEff;
        rxThresh_r  <= cfgRxThresh;
      end
      if (txStart && !txPend_r) begin
        txPend_r <= 1'b1;
        isData_r <= txIsData;
        len_r    <= txLen;
        retry_r  <= 1'b0;
      end
      if (rxHold) farHold_r <= 1'b1;
      else if ((rxPrim && !rxAlign) || rxDataW) farHold_r <= 1'b0;
      if (st_r == ST_TSOF) idx_r <= 5'h00;
      else if (take) idx_r <= idx_r + 5'h01;
      // Rejection of a non-data frame keeps it pending from the saved copy
      if (((st_r == ST_TWAIT) && rxRerr) || txFault) begin
        txPend_r <= !isData_r;
        retry_r  <= !isData_r;
      end else if ((st_r == ST_TWAIT) && rxRok) begin
        txPend_r <= 1'b0;
        retry_r  <= 1'b0;
      end
    end
  end

  // Transmit buffer pointers, saved copy of non-data frame, scrambler and CRC
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tbWp_r     <= 1'b0;
      tbRp_r     <= 1'b0;
      tbCnt_r    <= 2'h0;
      scrTx_r    <= SCR_SEED;
      scrTxCnt_r <= 11'h000;
      txCrc_r    <= CRC_SEED;
    end else begin
      if (tbPush) tbWp_r <= !tbWp_r;
      if (tbPop) tbRp_r <= !tbRp_r;
      tbCnt_r <= tbCnt_r + {1'b0, tbPush} - {1'b0, tbPop};
      if (st_r == ST_TSOF) begin
        scrTx_r    <= SCR_SEED;
        scrTxCnt_r <= 11'h000;
        txCrc_r    <= CRC_SEED;
      end else if (scrTxAdv) begin
        scrTx_r    <= (scrTxCnt_r == SCR_LAST) ? SCR_SEED : scrTxN[47:32];
        scrTxCnt_r <= scrTxCnt_r + 11'h001;
        if (take) txCrc_r <= crcStep(txCrc_r, srcWord);
      end
    end
  end

  // Storage arrays carry no reset; pointers and counts guard them
  always_ff @(posedge clk_sys) begin
    if (tbPush) tbMem[tbWp_r] <= txWord;
    if (tbPop && !isData_r) ctlMem[idx_r] <= srcWord;
    if (rfPush) rfMem[rfWp_r] <= pendWord_r;
  end

  // Receive pipeline: descramble, delay one word, CRC and FIFO fill
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scrRx_r    <= SCR_SEED;
      scrRxCnt_r <= 11'h000;
      rxCrc_r    <= CRC_SEED;
      pendV_r    <= 1'b0;
      pendWord_r <= 32'h00000000;
      rfWp_r     <= 4'h0;
      rfRp_r     <= 4'h0;
      rfCnt_r    <= 5'h00;
      rxFirst_r  <= 1'b0;
      rxBad_r    <= 1'b0;
      vendor_r   <= 1'b0;
      vSig_r     <= 1'b0;
      isDataRx_r <= 1'b0;
    end else begin
      if ((st_r == ST_RRDY) && rxSof) begin
        scrRx_r    <= SCR_SEED;
        scrRxCnt_r <= 11'h000;
        rxCrc_r    <= CRC_SEED;
        pendV_r    <= 1'b0;
        rxFirst_r  <= 1'b1;
        rxBad_r    <= 1'b0;
        vendor_r   <= 1'b0;
        vSig_r     <= 1'b0;
        isDataRx_r <= 1'b0;
      end else if (rxTake) begin
        scrRx_r    <= (scrRxCnt_r == SCR_LAST) ? SCR_SEED : scrRxN[47:32];
        scrRxCnt_r <= scrRxCnt_r + 11'h001;
        pendWord_r <= rxDw;
        pendV_r    <= 1'b1;
        if (pendV_r) rxCrc_r <= crcStep(rxCrc_r, pendWord_r);
      end
      if (rfPushRq && rxFirst_r) begin
        rxFirst_r  <= 1'b0;
        vendor_r   <= frmType;
        isDataRx_r <= pendWord_r[7:0] == FT_DATA;
      end
      if (vendor_r && rxHoldRq) vSig_r <= 1'b1;
      if (rxFrmErr || rxWtrm || (rfPushRq && !rfPush)) rxBad_r <= 1'b1;
      else if ((st_r == ST_RDATA) && rxEof && !crcMatch) rxBad_r <= 1'b1;
      if (rfPush) rfWp_r <= rfWp_r + 4'h1;
      if (rfPop) rfRp_r <= rfRp_r + 4'h1;
      rfCnt_r <= rfCnt_r + {4'h0, rfPush} - {4'h0, rfPop};
    end
  end

  // Event pulses and status levels (lineGen2, linkUp) toward transport and command layers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {txOk, txNotOk, txErr, rxFisGood, rxDataFis, rxVendorLong} <= 6'h00;
      {rxCrcOk, rxCrcBad, rxErrDisp, rxErrCode, rxErr}           <= 5'h00;
      {pmStart, lineGen2, linkUp, linkChange}                    <= 4'h0;
    end else begin
      txOk       <= (st_r == ST_TWAIT) && rxRok;
      txNotOk    <= (st_r == ST_TWAIT) && rxRerr;
      txErr      <= txFault;
      rxCrcOk    <= (st_r == ST_RDATA) && rxEof && crcMatch;
      rxCrcBad   <= (st_r == ST_RDATA) && rxEof && !crcMatch;
      rxFisGood  <= (st_r == ST_RDATA) && rxEof && crcMatch && !isDataRx_r
                    && !vSig_r && !rxBad_r;
      rxDataFis  <= rfPush && rxFirst_r && (pendWord_r[7:0] == FT_DATA);
      rxVendorLong <= vendor_r && !vSig_r && rxHoldRq;
      rxErrDisp  <= rxFrmErr && rxS_r.errDisp;
      rxErrCode  <= rxFrmErr && rxS_r.errCode;
      rxErr      <= ((st_r == ST_RDATA) && rxWtrm) || rxAbort;
      pmStart    <= pmReq && (st_r == ST_IDLE) && (lowPowerEnableBits != 2'h0);
      lineGen2   <= cfgGen2;
      linkUp     <= rdyS_r;
      linkChange <= rdyS_r ^ rdyPrev_r;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_align_pair;
    (phyTxData == P_ALIGN && phyTxIsK) ##1 (phyTxData == P_ALIGN && phyTxIsK);
  endsequence
  sequence s_crc_out;
    !phyTxIsK && (phyTxData == $past(txCrc_r ^ scrTxN[31:0]));
  endsequence

  a_align_two_words: assert property (alignLeft_r == 2'h2 |=> s_align_pair)
    else $error("ALIGN pair not sent");
  a_sof_leads: assert property ((st_r == ST_TSOF) && !alignNow
    |=> phyTxData == P_SOF && st_r == ST_TDATA)
    else $error("SOF missing before payload");
  a_eof_closes: assert property ((st_r == ST_TEOF) && !alignNow && rdyS_r && !rxSync
    |=> phyTxData == P_EOF ##1 st_r == ST_TWAIT)
    else $error("EOF missing after CRC");
  a_crc_scrambled: assert property ((st_r == ST_TCRC) && !alignNow |=> s_crc_out)
    else $error("CRC word not scrambled");
  a_hold_underflow: assert property ((st_r == ST_TDATA) && !alignNow && !farHold_r
    && !srcValid |=> phyTxData == P_HOLD)
    else $error("HOLD not sent on empty source");
  a_holda_answer: assert property ((st_r == ST_TDATA) && !alignNow && farHold_r
    |=> phyTxData == P_HOLDA)
    else $error("HOLDA not sent to far HOLD");
  a_rx_hold: assert property ((st_r == ST_RDATA) && !alignNow && rxHoldRq
    |=> phyTxData == P_HOLD)
    else $error("HOLD not sent at threshold");
  a_host_backs: assert property ((st_r == ST_IDLE) && rxXrdy && rdyS_r
    |=> st_r == ST_RRDY)
    else $error("Host did not yield");
  a_link_change: assert property ($changed(rdyS_r) |=> linkChange ##1 !linkChange)
    else $error("Link change not reported");
  a_pm_gated: assert property (lowPowerEnableBits == 2'h0 |=> !pmStart)
    else $error("Power request acted while disabled");
  a_retry_kept: assert property ((st_r == ST_TWAIT) && rxRerr && !isData_r && rdyS_r
    |=> retry_r && txPend_r ##1 st_r == ST_TRDY)
    else $error("Non-data frame not retried");
  a_crc_verdict: assert property ((st_r == ST_RDATA) && rxEof && rdyS_r
    |=> (rxCrcOk != rxCrcBad) ##1 st_r == ST_REND)
    else $error("CRC verdict missing");
  a_status_ok: assert property ((st_r == ST_REND) && !alignNow && !rxBad_r
    |=> phyTxData == P_ROK)
    else $error("R_OK not sent");

endmodule : stl_transport_link

// >>> test/stl_far_end.sv
// Far-end link partner model: answers handshakes, bench injects frames
`timescale 1ns/1ps
module stl_far_end import stl_pkg::*; (
  input  logic             clk_sys,
  input  logic [31:0]      phyTxData,
  input  logic             phyTxIsK,
  input  logic             nack,
  input  logic             injOn,
  input  stl_phy_word_type inj,
  output stl_phy_word_type phyRx
);
  logic [31:0] reply = P_SYNC;
  // Track host primitives; status is only given once WTRM is seen
  always @(negedge clk_sys) begin
    if (!phyTxIsK) reply <= P_RIP;
    else if (phyTxData == P_XRDY) reply <= P_RRDY;
    else if (phyTxData == P_WTRM) reply <= nack ? P_RERR : P_ROK;
    else if (phyTxData == P_SYNC) reply <= P_SYNC;
  end
  // Injected frames win so the bench owns the receive direction
  assign phyRx = injOn ? inj : '{reply, 1'b1, 1'b0, 1'b0};
endmodule : stl_far_end

// >>> test/stl_transport_link_tb.sv
// Self-checking bench for the transport and link layer framer
`timescale 1ns/1ps
module stl_transport_link_tb import stl_pkg::*;;
  logic             clk_sys = 0, rst_n = 0, txValid = 0, txStart = 0, txIsData = 0;
  logic             sendCtrlFrameReq = 0, rxOutReady = 0, phyReady = 0, cfgGen2 = 0;
  logic             pmReq = 0, nack = 0, injOn = 0;
  logic [4:0]       txLen = 5'h02;
  logic [3:0]       cfgRxThresh = 4'h8;
  logic [7:0]       cfgAlignRate = 8'h00;
  logic [1:0]       lowPowerEnableBits = 2'h0;
  stl_tx_word_type  txWord = '0;
  stl_phy_word_type phyRx, inj = '0;
  logic [31:0]      rxOut, phyTxData;
  logic             txReady, txOk, txNotOk, txErr, rxOutValid, rxFisGood, rxDataFis;
  logic             rxVendorLong, rxCrcOk, rxCrcBad, rxErrDisp, rxErrCode, rxErr;
  logic             phyTxIsK, pmStart, lineGen2, linkUp, linkChange;
  int               n_mismatch = 0, checks_done = 0, nChg = 0, nPm = 0, nOk = 0;
  int               nNok = 0, nBad = 0, nDisp = 0, nErr = 0, nGood = 0, nCok = 0;
  stl_transport_link dut (.clk_sys, .rst_n, .txWord, .txValid, .txReady, .txStart,
    .txIsData, .txLen, .sendCtrlFrameReq, .txOk, .txNotOk, .txErr, .rxOut, .rxOutValid,
    .rxOutReady, .rxFisGood, .rxDataFis, .rxVendorLong, .rxCrcOk, .rxCrcBad, .rxErrDisp,
    .rxErrCode, .rxErr, .phyRx, .phyReady, .phyTxData, .phyTxIsK, .cfgRxThresh,
    .cfgAlignRate, .lowPowerEnableBits, .cfgGen2, .pmReq, .pmStart, .lineGen2, .linkUp,
    .linkChange);
  stl_far_end far (.clk_sys, .phyTxData, .phyTxIsK, .nack, .injOn, .inj, .phyRx);
  // Clock
  initial forever #5 clk_sys = ~clk_sys;
  // Pulses last one cycle, so count them as they pass
  always @(posedge clk_sys) begin
    if (linkChange) nChg++;
    if (pmStart) nPm++;
    if (txOk) nOk++;
    if (txNotOk) nNok++;
    if (rxCrcBad) nBad++;
    if (rxErrDisp) nDisp++;
    if (rxErr) nErr++;
    if (rxFisGood) nGood++;
    if (rxCrcOk) nCok++;
  end
  // Scrambler word number n (from 1) after a fresh seed
  function automatic logic [31:0] scrW(input int n);
    logic [15:0] s;
    logic [31:0] o;
    s = SCR_SEED;
    o = '0;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 32; i++) begin
        o[i] = s[15];
        s = {s[14:0], 1'b0} ^ (s[15] ? SCR_POLY : 16'h0000);
      end
    end
    return o;
  endfunction : scrW
  // Frame CRC of a one-word frame, msb first from the seed
  function automatic logic [31:0] crcW(input logic [31:0] d);
    logic [31:0] r;
    r = CRC_SEED;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction : crcW
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // Bounded waits; running out counts as a mismatch and ends the run
  task waitPrim(input logic [31:0] p);
    int i;
    for (i = 0; i < 400 && !(phyTxIsK === 1'b1 && phyTxData === p); i++) @(negedge clk_sys);
    if (i == 400) chk(64'h0bad, 64'h0);
    if (i == 400) test_done();
  endtask : waitPrim
  task automatic waitCnt(ref int c, input int v);
    int i;
    for (i = 0; i < 400 && c < v; i++) @(negedge clk_sys);
    chk(c, v);
    if (i == 400) test_done();
  endtask : waitCnt
  // Word stays offered until the buffer takes it; caller drops valid
  task push(input logic [31:0] d);
    int i;
    txWord = '{d, 1'b0};
    txValid = 1;
    for (i = 0; i < 50 && txReady !== 1'b1; i++) @(negedge clk_sys);
    if (i == 50) chk(64'h0bad, 64'h0);
    if (i == 50) test_done();
    @(negedge clk_sys);
  endtask : push
  task scenIdle();
    phyReady = 1;
    repeat (6) @(negedge clk_sys);
    chk({linkUp, 31'h0, nChg}, {1'b1, 31'h0, 32'h1});
    pmReq = 1;
    @(negedge clk_sys);
    pmReq = 0;
    lowPowerEnableBits = 2'h1;
    cfgGen2 = 1;
    repeat (3) @(negedge clk_sys);
    chk(nPm, 0);
    pmReq = 1;
    @(negedge clk_sys);
    pmReq = 0;
    repeat (3) @(negedge clk_sys);
    chk({lineGen2, nPm}, {1'b1, 32'h1});
  endtask : scenIdle
  // Rejected non-data frame is sent again until accepted
  task scenTx();
    nack = 1;
    push(32'h11223344);
    push(32'h55667788);
    txValid = 0;
    chk(txReady, 0);
    txStart = 1;
    @(negedge clk_sys);
    txStart = 0;
    waitPrim(P_SOF);
    @(negedge clk_sys);
    chk({phyTxIsK, phyTxData}, {1'b0, 32'h11223344 ^ scrW(1)});
    waitPrim(P_EOF);
    waitCnt(nNok, 1);
    nack = 0;
    waitCnt(nOk, 1);
  endtask : scenTx
  // Mode 0: disparity error and wrong CRC; 1: cut by early WTRM; 2: clean frame
  task scenRx(input int mode);
    logic [31:0] w1;
    w1 = (mode == 2) ? (crcW(32'h00000027) ^ scrW(2)) : 32'h12345678;
    inj = '{P_XRDY, 1'b1, 1'b0, 1'b0};
    injOn = 1;
    waitPrim(P_RRDY);
    inj = '{P_SOF, 1'b1, 1'b0, 1'b0};
    @(negedge clk_sys);
    inj = '{32'h00000027 ^ scrW(1), 1'b0, mode == 0, 1'b0};
    @(negedge clk_sys);
    inj = '{w1, 1'b0, 1'b0, 1'b0};
    @(negedge clk_sys);
    inj = '{(mode == 1) ? P_WTRM : P_EOF, 1'b1, 1'b0, 1'b0};
    if (mode == 0) waitPrim(P_RERR);
    if (mode == 2) waitPrim(P_ROK);
    repeat (4) @(negedge clk_sys);
    inj = '{P_SYNC, 1'b1, 1'b0, 1'b0};
    repeat (6) @(negedge clk_sys);
    injOn = 0;
    if (mode == 1) chk(nErr, 1);
    if (mode == 0) chk(rxOut, 32'h00000027);
    if (mode == 0) chk({nBad, nDisp}, {32'h1, 32'h1});
    if (mode == 2) chk({nGood, nCok}, {32'h1, 32'h1});
    rxOutReady = 1;
  endtask : scenRx
  initial begin
    repeat (20) @(negedge clk_sys);
    chk({phyTxIsK, phyTxData, txReady, linkUp}, {1'b1, P_SYNC, 1'b1, 1'b0});
    rst_n = 1;
    scenIdle();
    scenTx();
    scenRx(0);
    scenRx(1);
    scenRx(2);
    phyReady = 0;
    repeat (6) @(negedge clk_sys);
    chk({linkUp, 31'h0, nChg}, {1'b0, 31'h0, 32'h2});
    test_done();
  end
endmodule : stl_transport_link_tb
